// >>> core/faee_pkg.sv
// constants for the flash array ecc engine
package faee_pkg;
	localparam int DATA_W = 128;
	localparam int BYTES = 16;
	localparam int SYN_W = 8;
	localparam int CODE_W = 9;
	localparam int POS_MAX = 256;
	localparam logic [31:0] ADR_CFG_PERS = 32'h00000005;
	localparam logic [31:0] ADR_CFG_LIVE = 32'h00800005;
	localparam logic [31:0] ADR_STATUS = 32'h00800089;
	localparam logic [31:0] ADR_CNT_LO = 32'h0080008A;
	localparam logic [31:0] ADR_CNT_HI = 32'h0080008B;
	localparam logic [31:0] ADR_TRAP0 = 32'h0080008E;
	localparam logic [31:0] ADR_TRAP1 = 32'h0080008F;
	localparam logic [31:0] ADR_TRAP2 = 32'h00800040;
	localparam logic [31:0] ADR_TRAP3 = 32'h00800041;
	localparam int CFG_DED_BIT = 3;
	localparam logic [7:0] CFG_RESET = 8'h08;
	localparam int ST_SBC_BIT = 3;
	localparam int ST_DED_BIT = 4;
	localparam int ST_PERR_BIT = 7;
	localparam int US_OFF_BIT = 0;
	localparam int US_SBC_BIT = 1;
	localparam int US_DED_BIT = 3;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [DATA_W-1:0] ERASED = {DATA_W{1'b1}};
endpackage

// >>> core/faee_engine.sv
// flash array ecc engine: per-unit check codes, correction, error reporting
`timescale 1ns/1ps
`default_nettype none
module faee_engine #(
	parameter int UNITS = 16,
	parameter int UNITS_PER_SECTOR = 4,
	localparam int UW = (UNITS > 1) ? $clog2(UNITS) : 1,
	localparam int SECTORS = UNITS / UNITS_PER_SECTOR,
	localparam int SW = (SECTORS > 1) ? $clog2(SECTORS) : 1
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PRG_REQ,
	input wire logic [UW-1:0] PRG_UNIT,
	input wire logic [faee_pkg::DATA_W-1:0] PRG_DATA,
	input wire logic [faee_pkg::BYTES-1:0] PRG_BE,
	input wire logic ERS_REQ,
	input wire logic [SW-1:0] ERS_SECTOR,
	input wire logic RD_REQ,
	input wire logic [UW-1:0] RD_UNIT,
	input wire logic [31:0] RD_ADDR,
	input wire logic UST_REQ,
	input wire logic [UW-1:0] UST_UNIT,
	input wire logic FLT_REQ,
	input wire logic [UW-1:0] FLT_UNIT,
	input wire logic [faee_pkg::DATA_W-1:0] FLT_DATA,
	input wire logic [faee_pkg::CODE_W-1:0] FLT_CODE,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic CLR_REQ,
	output logic PRG_DONE,
	output logic PRG_ERR,
	output logic RD_VALID,
	output logic [faee_pkg::DATA_W-1:0] RD_DATA,
	output logic RD_CORR,
	output logic RD_DBL,
	output logic UST_VALID,
	output logic [7:0] UST_DATA,
	output logic REG_RVALID,
	output logic [7:0] REG_RDATA
);
	// hamming syndrome bits over data; data bit k sits at k-th non-power-of-two position
	function automatic logic [faee_pkg::SYN_W-1:0] faee_hsyn(input logic [faee_pkg::DATA_W-1:0] d);
		logic [faee_pkg::SYN_W-1:0] s;
		int k;
		s = '0;
		k = 0;
		for (int p = 3; p < faee_pkg::POS_MAX; p++) begin
			if (((p & (p - 1)) != 0) && (k < faee_pkg::DATA_W)) begin
				if (d[k]) begin
					s = s ^ p[faee_pkg::SYN_W-1:0];
				end
				k++;
			end
		end
		return s;
	endfunction
	// data bit whose own syndrome matches; none for check-bit positions
	function automatic logic [faee_pkg::DATA_W-1:0] faee_flip(input logic [faee_pkg::SYN_W-1:0] syn);
		logic [faee_pkg::DATA_W-1:0] m;
		for (int k = 0; k < faee_pkg::DATA_W; k++) begin
			m[k] = (faee_hsyn({{(faee_pkg::DATA_W-1){1'b0}}, 1'b1} << k) == syn);
		end
		return m;
	endfunction
	// code word: overall parity only in double-bit mode
	function automatic logic [faee_pkg::CODE_W-1:0] faee_gen(input logic [faee_pkg::DATA_W-1:0] d, input logic ded);
		logic [faee_pkg::SYN_W-1:0] s;
		s = faee_hsyn(d);
		return {ded & ((^d) ^ (^s)), s};
	endfunction

	wire logic [faee_pkg::DATA_W-1:0] data_arr [UNITS];
	wire logic [faee_pkg::CODE_W-1:0] code_arr [UNITS];
	wire logic prog_arr [UNITS];
	wire logic off_arr [UNITS];
	wire logic sbc_arr [UNITS];
	wire logic ded_arr [UNITS];
	logic [7:0] live_reg, live_next;
	logic [7:0] pers_reg, pers_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [31:0] trap_reg, trap_next;
	logic st_sbc_reg, st_sbc_next;
	logic st_ded_reg, st_ded_next;
	logic st_perr_reg, st_perr_next;
	logic prg_done_next;
	logic prg_err_next;
	logic rd_valid_next;
	logic [faee_pkg::DATA_W-1:0] rd_data_next;
	logic rd_corr_next;
	logic rd_dbl_next;
	logic ust_valid_next;
	logic [7:0] ust_data_next;
	logic reg_rvalid_next;
	logic [7:0] reg_rdata_next;
	logic ded_mode;
	logic mode_chg;
	logic prg_reject;
	logic [faee_pkg::DATA_W-1:0] rd_raw;
	logic [faee_pkg::CODE_W-1:0] rd_code;
	logic [faee_pkg::SYN_W-1:0] rd_syn;
	logic rd_pe;
	logic rd_chk;
	logic rd_single;
	logic rd_double;
	always_comb begin
		ded_mode = live_reg[faee_pkg::CFG_DED_BIT];
		mode_chg = REG_WR && (REG_ADDR == faee_pkg::ADR_CFG_LIVE)
			&& (REG_WDATA[faee_pkg::CFG_DED_BIT] != ded_mode);
		prg_reject = PRG_REQ && ded_mode && prog_arr[PRG_UNIT];
		rd_raw = data_arr[RD_UNIT];
		rd_code = code_arr[RD_UNIT];
		rd_syn = faee_hsyn(rd_raw) ^ rd_code[faee_pkg::SYN_W-1:0];
		rd_pe = (^rd_raw) ^ (^rd_code);
		rd_chk = RD_REQ && prog_arr[RD_UNIT] && !off_arr[RD_UNIT];
		rd_single = rd_chk && (ded_mode ? rd_pe : (rd_syn != '0));
		rd_double = rd_chk && ded_mode && !rd_pe && (rd_syn != '0);
	end
	// per-unit storage: data, code, programmed, correction-off, last-read flags
	for (genvar u = 0; u < UNITS; u++) begin : g_unit
		logic [faee_pkg::DATA_W-1:0] d_reg, d_next;
		logic [faee_pkg::CODE_W-1:0] c_reg, c_next;
		logic p_reg, p_next;
		logic o_reg, o_next;
		logic s_reg, s_next;
		logic e_reg, e_next;
		logic ers_hit;
		always_comb begin
			d_next = d_reg;
			c_next = c_reg;
			p_next = p_reg;
			o_next = o_reg;
			s_next = s_reg;
			e_next = e_reg;
			ers_hit = ERS_REQ && ((u / UNITS_PER_SECTOR) == int'(ERS_SECTOR));
			if (ers_hit) begin
				d_next = faee_pkg::ERASED;
				c_next = '0;
				p_next = 1'b0;
				o_next = 1'b0;
				s_next = 1'b0;
				e_next = 1'b0;
			end else begin
				if (PRG_REQ && (int'(PRG_UNIT) == u) && !prg_reject) begin
					for (int b = 0; b < faee_pkg::BYTES; b++) begin
						if (PRG_BE[b]) begin
							d_next[b*8 +: 8] = d_reg[b*8 +: 8] & PRG_DATA[b*8 +: 8];
						end
					end
					if (!p_reg) begin
						c_next = faee_gen(d_next, ded_mode);
						p_next = 1'b1;
					end else begin
						o_next = 1'b1;
					end
				end
				if (FLT_REQ && (int'(FLT_UNIT) == u)) begin
					d_next = d_next ^ FLT_DATA;
					c_next = c_next ^ FLT_CODE;
				end
				if (mode_chg && p_reg) begin
					o_next = 1'b1;
				end
				if (RD_REQ && (int'(RD_UNIT) == u)) begin
					s_next = rd_single;
					e_next = rd_double;
				end
			end
		end
		always_ff @(posedge MCLK) begin
			if (SYS_RST) begin
				d_reg <= faee_pkg::ERASED;
				c_reg <= '0;
				p_reg <= 1'b0;
				o_reg <= 1'b0;
				s_reg <= 1'b0;
				e_reg <= 1'b0;
			end else begin
				d_reg <= d_next;
				c_reg <= c_next;
				p_reg <= p_next;
				o_reg <= o_next;
				s_reg <= s_next;
				e_reg <= e_next;
			end
		end
		assign data_arr[u] = d_reg;
		assign code_arr[u] = c_reg;
		assign prog_arr[u] = p_reg;
		assign off_arr[u] = o_reg;
		assign sbc_arr[u] = s_reg;
		assign ded_arr[u] = e_reg;
	end

	// control, reporting and register command group
	always_comb begin
		live_next = live_reg;
		pers_next = pers_reg;
		cnt_next = cnt_reg;
		trap_next = trap_reg;
		st_sbc_next = st_sbc_reg;
		st_ded_next = st_ded_reg;
		st_perr_next = st_perr_reg;
		if (CLR_REQ) begin
			cnt_next = '0;
			trap_next = '0;
			st_sbc_next = 1'b0;
			st_ded_next = 1'b0;
			st_perr_next = 1'b0;
		end
		// set after clear so a same-cycle event survives
		if (rd_single || rd_double) begin
			if (cnt_next != faee_pkg::CNT_MAX) begin
				cnt_next = cnt_next + 16'h0001;
			end
			if (!st_sbc_next && !st_ded_next) begin
				trap_next = RD_ADDR;
			end
			st_sbc_next = st_sbc_next | rd_single;
			st_ded_next = st_ded_next | rd_double;
		end
		if (prg_reject) begin
			st_perr_next = 1'b1;
		end
		if (REG_WR) begin
			if (REG_ADDR == faee_pkg::ADR_CFG_LIVE) begin
				live_next = REG_WDATA;
			end else if (REG_ADDR == faee_pkg::ADR_CFG_PERS) begin
				pers_next = REG_WDATA;
			end
		end
		prg_done_next = PRG_REQ && !prg_reject;
		prg_err_next = prg_reject;
		rd_valid_next = RD_REQ;
		rd_data_next = rd_raw;
		if (rd_single) begin
			rd_data_next = rd_raw ^ faee_flip(rd_syn);
		end
		rd_corr_next = rd_single;
		rd_dbl_next = rd_double;
		ust_valid_next = UST_REQ;
		ust_data_next = '0;
		ust_data_next[faee_pkg::US_OFF_BIT] = off_arr[UST_UNIT];
		ust_data_next[faee_pkg::US_SBC_BIT] = sbc_arr[UST_UNIT];
		ust_data_next[faee_pkg::US_DED_BIT] = ded_arr[UST_UNIT] & ded_mode;
		reg_rvalid_next = REG_RD;
		reg_rdata_next = '0;
		if (REG_ADDR == faee_pkg::ADR_CFG_LIVE) begin
			reg_rdata_next = live_reg;
		end else if (REG_ADDR == faee_pkg::ADR_CFG_PERS) begin
			reg_rdata_next = pers_reg;
		end else if (REG_ADDR == faee_pkg::ADR_STATUS) begin
			reg_rdata_next[faee_pkg::ST_SBC_BIT] = st_sbc_reg;
			reg_rdata_next[faee_pkg::ST_DED_BIT] = st_ded_reg & ded_mode;
			reg_rdata_next[faee_pkg::ST_PERR_BIT] = st_perr_reg;
		end else if (REG_ADDR == faee_pkg::ADR_CNT_LO) begin
			reg_rdata_next = cnt_reg[7:0];
		end else if (REG_ADDR == faee_pkg::ADR_CNT_HI) begin
			reg_rdata_next = cnt_reg[15:8];
		end else if (REG_ADDR == faee_pkg::ADR_TRAP0) begin
			reg_rdata_next = trap_reg[7:0];
		end else if (REG_ADDR == faee_pkg::ADR_TRAP1) begin
			reg_rdata_next = trap_reg[15:8];
		end else if (REG_ADDR == faee_pkg::ADR_TRAP2) begin
			reg_rdata_next = trap_reg[23:16];
		end else if (REG_ADDR == faee_pkg::ADR_TRAP3) begin
			reg_rdata_next = trap_reg[31:24];
		end
		if (!REG_RD) begin
			reg_rdata_next = REG_RDATA;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			live_reg <= faee_pkg::CFG_RESET;
			pers_reg <= faee_pkg::CFG_RESET;
			cnt_reg <= '0;
			trap_reg <= '0;
			st_sbc_reg <= 1'b0;
			st_ded_reg <= 1'b0;
			st_perr_reg <= 1'b0;
			PRG_DONE <= 1'b0;
			PRG_ERR <= 1'b0;
			RD_VALID <= 1'b0;
			RD_DATA <= '0;
			RD_CORR <= 1'b0;
			RD_DBL <= 1'b0;
			UST_VALID <= 1'b0;
			UST_DATA <= '0;
			REG_RVALID <= 1'b0;
			REG_RDATA <= '0;
		end else begin
			live_reg <= live_next;
			pers_reg <= pers_next;
			cnt_reg <= cnt_next;
			trap_reg <= trap_next;
			st_sbc_reg <= st_sbc_next;
			st_ded_reg <= st_ded_next;
			st_perr_reg <= st_perr_next;
			PRG_DONE <= prg_done_next;
			PRG_ERR <= prg_err_next;
			RD_VALID <= rd_valid_next;
			RD_DATA <= rd_data_next;
			RD_CORR <= rd_corr_next;
			RD_DBL <= rd_dbl_next;
			UST_VALID <= ust_valid_next;
			UST_DATA <= ust_data_next;
			REG_RVALID <= reg_rvalid_next;
			REG_RDATA <= reg_rdata_next;
		end
	end
endmodule
`default_nettype wire

// >>> tb/faee_host.sv
// host controller model driving the ecc engine request ports
`timescale 1ns/1ps
`default_nettype none
module faee_host (
	input wire logic MCLK,
	output logic PRG_REQ = 1'b0, ERS_REQ = 1'b0, RD_REQ = 1'b0, UST_REQ = 1'b0,
	output logic FLT_REQ = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, CLR_REQ = 1'b0,
	output logic [3:0] PRG_UNIT = 4'h0, RD_UNIT = 4'h0, UST_UNIT = 4'h0, FLT_UNIT = 4'h0,
	output logic [1:0] ERS_SECTOR = 2'h0,
	output logic [127:0] PRG_DATA = 128'h0, FLT_DATA = 128'h0,
	output logic [15:0] PRG_BE = 16'h0,
	output logic [31:0] RD_ADDR = 32'h0, REG_ADDR = 32'h0,
	output logic [8:0] FLT_CODE = 9'h0,
	output logic [7:0] REG_WDATA = 8'h0
);
	// drop strobe after the taking edge, return once the answer has landed
	task automatic fin;
		@(posedge MCLK);
		{PRG_REQ, ERS_REQ, RD_REQ, UST_REQ, FLT_REQ, REG_WR, REG_RD, CLR_REQ} <= 8'h00;
		#1;
	endtask
	task automatic prg(input logic [3:0] u, input logic [127:0] d, input logic [15:0] b);
		@(posedge MCLK);
		{PRG_UNIT, PRG_DATA, PRG_BE, PRG_REQ} <= {u, d, b, 1'b1};
		fin;
	endtask
	task automatic ers(input logic [1:0] s);
		@(posedge MCLK);
		{ERS_SECTOR, ERS_REQ} <= {s, 1'b1};
		fin;
	endtask
	task automatic rd(input logic [3:0] u, input logic [31:0] a);
		@(posedge MCLK);
		{RD_UNIT, RD_ADDR, RD_REQ} <= {u, a, 1'b1};
		fin;
	endtask
	task automatic flt(input logic [3:0] u, input logic [127:0] d);
		@(posedge MCLK);
		{FLT_UNIT, FLT_DATA, FLT_CODE, FLT_REQ} <= {u, d, 9'h000, 1'b1};
		fin;
	endtask
	task automatic ust(input logic [3:0] u);
		@(posedge MCLK);
		{UST_UNIT, UST_REQ} <= {u, 1'b1};
		fin;
	endtask
	task automatic rrd(input logic [31:0] a);
		@(posedge MCLK);
		{REG_ADDR, REG_RD} <= {a, 1'b1};
		fin;
	endtask
	task automatic rwr(input logic [31:0] a, input logic [7:0] w);
		@(posedge MCLK);
		{REG_ADDR, REG_WDATA, REG_WR} <= {a, w, 1'b1};
		fin;
	endtask
	task automatic clr;
		@(posedge MCLK);
		CLR_REQ <= 1'b1;
		fin;
	endtask
endmodule
`default_nettype wire

// >>> tb/faee_chk_assertions.sv
// handshake and read flag checker for the ecc engine
`timescale 1ns/1ps
`default_nettype none
module faee_chk (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PRG_REQ,
	input wire logic RD_REQ,
	input wire logic UST_REQ,
	input wire logic REG_RD,
	input wire logic PRG_DONE,
	input wire logic PRG_ERR,
	input wire logic RD_VALID,
	input wire logic RD_CORR,
	input wire logic RD_DBL,
	input wire logic UST_VALID,
	input wire logic REG_RVALID
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	chk_prg_answer: assert property (PRG_REQ |=> PRG_DONE != PRG_ERR) else $error("program unanswered");
	chk_prg_origin: assert property ((PRG_DONE || PRG_ERR) |-> $past(PRG_REQ)) else $error("stray program");
	chk_rd_answer: assert property (RD_REQ |=> RD_VALID) else $error("read unanswered");
	chk_rd_origin: assert property (RD_VALID |-> $past(RD_REQ)) else $error("stray read");
	chk_flag_excl: assert property (!(RD_CORR && RD_DBL)) else $error("both flags");
	chk_flag_idle: assert property (!RD_VALID |-> !RD_CORR && !RD_DBL) else $error("flag without read");
	chk_reg_answer: assert property (REG_RD |=> REG_RVALID ##1 !REG_RVALID || $past(REG_RD)) else $error("reg rd");
	chk_reg_origin: assert property (REG_RVALID |-> $past(REG_RD)) else $error("stray reg data");
	chk_ust_answer: assert property (UST_REQ |=> UST_VALID) else $error("status unanswered");
endmodule
bind faee_engine faee_chk faee_chk_i (.MCLK, .SYS_RST, .PRG_REQ, .RD_REQ, .UST_REQ, .REG_RD,
	.PRG_DONE, .PRG_ERR, .RD_VALID, .RD_CORR, .RD_DBL, .UST_VALID, .REG_RVALID);
`default_nettype wire

// >>> tb/flash_array_ecc_engine_bench.sv
// self-checking bench for the flash array ecc engine
`timescale 1ns/1ps
`default_nettype none
module flash_array_ecc_engine_bench;
	logic MCLK = 1'b0;
	logic SYS_RST = 1'b1;
	wire PRG_REQ, ERS_REQ, RD_REQ, UST_REQ, FLT_REQ, REG_WR, REG_RD, CLR_REQ;
	wire PRG_DONE, PRG_ERR, RD_VALID, RD_CORR, RD_DBL, UST_VALID, REG_RVALID;
	wire [3:0] PRG_UNIT, RD_UNIT, UST_UNIT, FLT_UNIT;
	wire [1:0] ERS_SECTOR;
	wire [127:0] PRG_DATA, FLT_DATA, RD_DATA;
	wire [15:0] PRG_BE;
	wire [31:0] RD_ADDR, REG_ADDR;
	wire [8:0] FLT_CODE;
	wire [7:0] REG_WDATA, UST_DATA, REG_RDATA;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	faee_host faee_host_i (.MCLK, .PRG_REQ, .ERS_REQ, .RD_REQ, .UST_REQ, .FLT_REQ, .REG_WR, .REG_RD,
		.CLR_REQ, .PRG_UNIT, .RD_UNIT, .UST_UNIT, .FLT_UNIT, .ERS_SECTOR, .PRG_DATA, .FLT_DATA,
		.PRG_BE, .RD_ADDR, .REG_ADDR, .FLT_CODE, .REG_WDATA);
	faee_engine faee_engine_i (.MCLK, .SYS_RST, .PRG_REQ, .PRG_UNIT, .PRG_DATA, .PRG_BE, .ERS_REQ,
		.ERS_SECTOR, .RD_REQ, .RD_UNIT, .RD_ADDR, .UST_REQ, .UST_UNIT, .FLT_REQ, .FLT_UNIT, .FLT_DATA,
		.FLT_CODE, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .CLR_REQ, .PRG_DONE, .PRG_ERR, .RD_VALID,
		.RD_DATA, .RD_CORR, .RD_DBL, .UST_VALID, .UST_DATA, .REG_RVALID, .REG_RDATA);
	initial forever #4 MCLK = ~MCLK;
	task automatic ck(input logic ok, input string m);
		checked++;
		if (!ok) begin
			$display("CHECK FAILED %0t %s", $time, m);
			n_errors++;
		end
	endtask
	task automatic rr(input logic [31:0] a, input logic [7:0] e);
		faee_host_i.rrd(a);
		ck(REG_RVALID === 1'b1 && REG_RDATA === e, "register value");
	endtask
	task test_done;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// erased unit with enabled bytes laid over it
	function automatic logic [127:0] merge(input logic [127:0] d, input logic [15:0] be);
		merge = faee_pkg::ERASED;
		for (int b = 0; b < 16; b++) if (be[b]) merge[8*b +: 8] = d[8*b +: 8];
	endfunction
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		logic [127:0] d, e, m1, m2;
		logic [15:0] be;
		logic [15:0] cnt;
		void'($urandom(32'hDE73));
		cnt = 16'h0000;
		repeat (12) @(posedge MCLK);
		SYS_RST <= 1'b0;
		rr(faee_pkg::ADR_CFG_LIVE, faee_pkg::CFG_RESET);
		rr(32'h00800007, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = {$urandom, $urandom, $urandom, $urandom};
			be = (i == 0) ? 16'h0001 : 16'($urandom | 1);
			e = merge(d, be);
			m1 = 128'h1 << ($urandom % 127);
			m2 = m1 << 1;
			faee_host_i.prg(4'(i), d, be);
			ck(PRG_DONE === 1'b1 && PRG_ERR === 1'b0, "program");
			faee_host_i.flt(4'(i), m1);
			faee_host_i.rd(4'(i), 32'h12A51000 + 32'(i) * 16);
			ck(RD_VALID === 1'b1 && RD_DATA === e && RD_CORR === 1'b1 && RD_DBL === 1'b0, "corr");
			faee_host_i.flt(4'(i), m2);
			faee_host_i.rd(4'(i), 32'h00000100);
			ck(RD_DATA === (e ^ m1 ^ m2) && RD_DBL === 1'b1 && RD_CORR === 1'b0, "double");
			cnt = cnt + 16'h0002;
		end
		rr(faee_pkg::ADR_CNT_LO, cnt[7:0]);
		rr(faee_pkg::ADR_CNT_HI, cnt[15:8]);
		rr(faee_pkg::ADR_TRAP0, 8'h00);
		rr(faee_pkg::ADR_TRAP1, 8'h10);
		rr(faee_pkg::ADR_TRAP2, 8'hA5);
		rr(faee_pkg::ADR_TRAP3, 8'h12);
		faee_host_i.prg(4'h0, d, 16'h0002);
		ck(PRG_ERR === 1'b1 && PRG_DONE === 1'b0, "reprogram");
		rr(faee_pkg::ADR_STATUS, 8'h98);
		for (int s = 0; s < 4; s++) faee_host_i.ers(2'(s));
		faee_host_i.rwr(faee_pkg::ADR_CFG_LIVE, 8'h00);
		rr(faee_pkg::ADR_CFG_LIVE, 8'h00);
		rr(faee_pkg::ADR_STATUS, 8'h88);
		faee_host_i.clr;
		rr(faee_pkg::ADR_TRAP1, 8'h00);
		rr(faee_pkg::ADR_CNT_LO, 8'h00);
		rr(faee_pkg::ADR_STATUS, 8'h00);
		d = {$urandom, $urandom, $urandom, $urandom};
		e = {$urandom, $urandom, $urandom, $urandom};
		faee_host_i.prg(4'h5, d, 16'hFFFF);
		faee_host_i.prg(4'h5, e, 16'h00F0);
		ck(PRG_DONE === 1'b1, "single reprogram");
		faee_host_i.ust(4'h5);
		ck(UST_VALID === 1'b1 && UST_DATA === 8'h01, "unit off");
		faee_host_i.flt(4'h5, 128'h1);
		faee_host_i.rd(4'h5, 32'h00000050);
		ck(RD_VALID === 1'b1 && RD_DATA === ((d & merge(e, 16'h00F0)) ^ 128'h1) && RD_CORR === 1'b0 && RD_DBL === 1'b0, "raw");
		faee_host_i.ers(2'h1);
		faee_host_i.ust(4'h5);
		ck(UST_VALID === 1'b1 && UST_DATA === 8'h00, "erase reenables");
		faee_host_i.prg(4'h4, d, 16'hFFFF);
		faee_host_i.flt(4'h4, 128'h3);
		faee_host_i.rd(4'h4, 32'h00000040);
		ck(RD_VALID === 1'b1 && RD_DBL === 1'b0, "no double flag");
		faee_host_i.rwr(faee_pkg::ADR_CFG_LIVE, faee_pkg::CFG_RESET);
		faee_host_i.ust(4'h4);
		ck(UST_VALID === 1'b1 && UST_DATA === 8'h03, "mode change invalidates");
		test_done;
	end
endmodule
`default_nettype wire
